// ===== gocd_assertions.sv
// Concurrent checks on the ports of the option decode block
`timescale 1ns/1ns
`default_nettype none
module gocd_checker import gocd_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [9:0] paddr_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic smb_clk_low_in,
  input wire logic smb_dat_low_in,
  input wire logic overtemp_in,
  input wire gocd_opts_t opts_out,
  input wire logic host_pec_out,
  input wire logic broadcast_en_out,
  input wire logic sleep_out,
  input wire logic chg_switch_on_out,
  input wire logic [2:0] precharge_sel_out
);
  // One clock domain, so one clocking and one reset for every check
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // Bus answers one cycle after setup and only for one cycle
  ready_in_time_a: assert property (psel_in && !penable_in |=> pready_out)
    else $error("ready late");
  ready_single_a: assert property (pready_out |=> !pready_out) else $error("ready held");
  bad_address_a: assert property (psel_in && !penable_in && paddr_in == 10'h3fc |=> pslverr_out)
    else $error("no error on unmapped");
  // Sleep only after a sampled quiet bus
  // The count that raised sleep saw the quiet bus two samples back
  sleep_cause_a: assert property ($rose(sleep_out) |-> $past(smb_clk_low_in && smb_dat_low_in, 2))
    else $error("sleep without quiet bus");
  segment_code_a: assert property (opts_out.segments inside {3'h0, 3'h3, 3'h4, 3'h5})
    else $error("bad segment count");
  cell_code_a: assert property (opts_out.cells inside {3'h0, 3'h2, 3'h3, 3'h4})
    else $error("bad cell count");
  bcast_block_a: assert property (opts_out.broadcast_disable [*2] |-> !broadcast_en_out)
    else $error("broadcast while disabled");
  host_pec_a: assert property (opts_out.host_alarm_checksum [*2] |-> host_pec_out)
    else $error("host checksum missing");
  hot_charge_off_a: assert property (overtemp_in [*2] |-> !chg_switch_on_out)
    else $error("charge switch on when hot");
  precharge_one_a: assert property ($onehot0(precharge_sel_out)) else $error("precharge");
endmodule
bind gocd_top gocd_checker gocd_checker_i (.clk_in, .rst_b_in, .psel_in, .penable_in,
  .paddr_in, .pready_out, .pslverr_out, .smb_clk_low_in, .smb_dat_low_in, .overtemp_in,
  .opts_out, .host_pec_out, .broadcast_en_out, .sleep_out, .chg_switch_on_out,
  .precharge_sel_out);
`default_nettype wire

// ===== gocd_pkg.sv
// Package for the gauge option and configuration decode block
package gocd_pkg;
  // Register word indices; the APB byte address is four times the index
  localparam logic [7:0] GOCD_REM_TIME_ALARM = 8'h02;
  localparam logic [7:0] GOCD_DESIGN_VOLTAGE = 8'h04;
  localparam logic [7:0] GOCD_CYCLE_INIT = 8'h0c;
  localparam logic [7:0] GOCD_PACK_OPT = 8'h28;
  localparam logic [7:0] GOCD_GAUGE_OPT = 8'h29;
  localparam logic [7:0] GOCD_MISC_OPT = 8'h2a;
  localparam logic [7:0] GOCD_FILTER = 8'h2c;
  localparam logic [7:0] GOCD_DESIGN_CAP = 8'h32;
  localparam logic [7:0] GOCD_FULL_CAP_INIT = 8'h36;
  localparam logic [7:0] GOCD_CYCLE_THRESH = 8'h37;
  localparam logic [7:0] GOCD_CHG_EFF = 8'h54;
  // Own registers: control, capacity alarm, status, counter, reported design capacity, remaining, filter in nV
  localparam logic [7:0] GOCD_CTRL = 8'h80;
  localparam logic [7:0] GOCD_CAP_ALARM = 8'h84;
  localparam logic [7:0] GOCD_STATUS = 8'h88;
  localparam logic [7:0] GOCD_CYCLE_COUNT = 8'h8c;
  localparam logic [7:0] GOCD_DESIGN_CAP_RPT = 8'h90;
  localparam logic [7:0] GOCD_REMAINING = 8'h94;
  localparam logic [7:0] GOCD_FILTER_NV = 8'h98;
  // Pack option bit positions
  localparam int GOCD_P_DSRC = 7;
  localparam int GOCD_P_LED_HI = 6;
  localparam int GOCD_P_LED_LO = 5;
  localparam int GOCD_P_HPEC = 4;
  localparam int GOCD_P_CPEC = 3;
  localparam int GOCD_P_BDIS = 2;
  localparam int GOCD_P_CELL_HI = 1;
  localparam int GOCD_P_CELL_LO = 0;
  // Gauge option bit positions
  localparam int GOCD_G_CAPACITY_SYNC_ON_TERM = 6;
  localparam int GOCD_G_INDEP = 5;
  localparam int GOCD_G_COMP = 4;
  localparam int GOCD_G_EDSRC = 3;
  localparam int GOCD_G_OVSRC = 2;
  localparam int GOCD_G_VCONT = 1;
  localparam int GOCD_G_VONCE = 0;
  // Misc option bit positions
  localparam int GOCD_M_ITEMP = 15;
  localparam int GOCD_M_AFECHK = 13;
  localparam int GOCD_M_SLPINH = 12;
  localparam int GOCD_M_OTDIS = 11;
  localparam int GOCD_M_DISPCHG = 10;
  localparam int GOCD_M_CDELAY = 8;
  localparam int GOCD_M_ABLANK = 7;
  localparam int GOCD_M_PRE_HI = 6;
  localparam int GOCD_M_PRE_LO = 5;
  localparam int GOCD_M_FIXED = 4;
  localparam int GOCD_M_CHOLD = 3;
  // Fixed-to-one misc bits, the writable misc bits, and the writable gauge bits
  localparam logic [15:0] GOCD_MISC_ONES = 16'h0200;
  localparam logic [15:0] GOCD_MISC_MASK = 16'hbdf8;
  localparam logic [7:0] GOCD_GAUGE_MASK = 8'h7f;
  // Control register bits
  localparam int GOCD_C_MWH = 0;
  localparam int GOCD_C_LOADED = 1;
  // Scaling constants
  localparam logic [15:0] GOCD_FILTER_STEP_NV = 16'd290;
  localparam logic [15:0] GOCD_MWH_DIV = 16'd10000; // mAh*mV to 10 mWh
  localparam logic [8:0] GOCD_EFF_ONE = 9'h100;
  // Timing: 2 s sleep, 1 s flag delay at 250 MHz
  localparam longint GOCD_CLK_HZ = 250000000;
  localparam longint GOCD_SLEEP_S = 2;
  localparam longint GOCD_CDELAY_S = 1;
  localparam longint GOCD_SLEEP_CYC = GOCD_SLEEP_S * GOCD_CLK_HZ;
  localparam longint GOCD_CDELAY_CYC = GOCD_CDELAY_S * GOCD_CLK_HZ;
  // Precharge switch codes
  typedef enum logic [1:0] {
    GOCD_PRE_ZERO_VOLT = 2'h0, GOCD_PRE_CHARGE = 2'h1, GOCD_PRE_DISCHG = 2'h2, GOCD_PRE_UNDEF = 2'h3
  } gocd_pre_t;
  // Decoded option bundle
  typedef struct packed {
    logic display_source_select;
    logic [2:0] segments;
    logic host_alarm_checksum;
    logic charger_broadcast_checksum;
    logic broadcast_disable;
    logic [2:0] cells;
    logic capacity_sync_on_term;
    logic independent_charger_learning;
    logic end_discharge_compensation;
    logic end_discharge_voltage_source;
    logic safety_overvoltage_source;
    logic internal_temp_sensor;
    logic front_end_comm_check;
    logic fixed_battery;
  } gocd_opts_t;
  // Measured inputs from the gauge core
  typedef struct packed {
    logic [15:0] pack_mv;
    logic [15:0] min_cell_mv;
    logic [15:0] max_cell_mv;
    logic [15:0] dis_mah;
    logic [15:0] chg_mah;
  } gocd_meas_t;
endpackage

// ===== gocd_smb_host.sv
// Host and charger bus activity model
`timescale 1ns/1ns
`default_nettype none
module gocd_smb_host (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic idle_in,
  output logic clk_low_out,
  output logic dat_low_out
);
  logic tog_q; // Traffic phase
  // A quiet bus leaves both lines low; traffic never holds both low
  always_ff @(posedge clk_in) begin
    tog_q <= rst_b_in && !tog_q;
    clk_low_out <= idle_in || tog_q;
    dat_low_out <= idle_in || !tog_q;
  end
endmodule
`default_nettype wire

// ===== gocd_top.sv
// Option decode and control behaviour of the gauge with its APB register bank
`timescale 1ns/1ns
`default_nettype none
module gocd_top import gocd_pkg::*; #(
  parameter longint SLEEP_CYC = GOCD_SLEEP_CYC,
  parameter longint CDELAY_CYC = GOCD_CDELAY_CYC
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [9:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire gocd_meas_t meas_in,
  input wire logic dis_pulse_in,
  input wire logic chg_pulse_in,
  input wire logic term_in,
  input wire logic [7:0] sync_pct_in,
  input wire logic smb_clk_low_in,
  input wire logic smb_dat_low_in,
  input wire logic overtemp_in,
  input wire logic cell_ov_in,
  input wire logic cell_uv_in,
  input wire logic cap_alarm_in,
  input wire logic charging_in,
  input wire logic blink_in,
  input wire logic [4:0] level_abs_in,
  input wire logic [4:0] level_rel_in,
  input wire logic fault_chg_in,
  input wire logic fault_dis_in,
  input wire logic fault_clear_in,
  input wire logic [15:0] safety_mv_in,
  output gocd_opts_t opts_out,
  output logic [4:0] display_out,
  output logic host_pec_out,
  output logic charger_pec_out,
  output logic broadcast_en_out,
  output logic sleep_out,
  output logic chg_switch_on_out,
  output logic dis_switch_on_out,
  output logic [2:0] precharge_sel_out,
  output logic cell_ov_flag_out,
  output logic cell_uv_flag_out,
  output logic edv_below_out,
  output logic safety_ov_out,
  output logic midrange_go_out,
  output logic edv_compute_out,
  output logic [15:0] filter_nv_out,
  output logic [15:0] remaining_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Segment count from the indicator field
  function automatic logic [2:0] seg_count(input logic [1:0] f);
    case (f)
      2'h1: seg_count = 3'h3;
      2'h2: seg_count = 3'h4;
      default: seg_count = 3'h5;
    endcase
  endfunction

  // Thermometer mask for a segment count
  function automatic logic [4:0] seg_mask(input logic [2:0] n);
    seg_mask = 5'(( 6'h1 << n) - 6'h1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [15:0] rem_time_q, design_v_q, cyc_init_q, misc_q, design_cap_q;
  logic [15:0] full_cap_q, cyc_thresh_q, cap_alarm_q, cyc_count_q;
  logic [7:0] pack_q, gauge_q, filter_q, eff_q;
  logic mwh_q;
  logic loaded_q; // Options loaded; before it options decode as defaults, but cell flags, filter_nv_out and remaining_out still update
  logic cyc_loaded_q;
  logic [15:0] rem_q, rem_d;
  logic [16:0] dis_acc_q; // Discharged charge since last cycle count
  logic [16:0] chg_acc_q; // Fractional charge accumulator, 8 fraction bits
  logic once_done_q; // One-time midrange correction consumed
  logic [31:0] sleep_cnt_q, delay_cnt_q;
  logic [15:0] design_rpt; // Reported design capacity, also readable

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire logic acc = psel_in && penable_in;
  wire logic wr = acc && pwrite_in;
  // Every register is one word; odd-numbered indices would clash as byte addresses
  wire logic [7:0] reg_idx = paddr_in[9:2];
  wire logic hit = (paddr_in[1:0] == 2'h0);
  logic [31:0] rd_mux;
  logic known;

  // Read multiplexer; narrow registers read in the low bits
  always_comb begin
    known = 1'b1;
    case (reg_idx)
      GOCD_REM_TIME_ALARM: rd_mux = {16'h0, rem_time_q};
      GOCD_DESIGN_VOLTAGE: rd_mux = {16'h0, design_v_q};
      GOCD_CYCLE_INIT: rd_mux = {16'h0, cyc_init_q};
      GOCD_PACK_OPT: rd_mux = {24'h0, pack_q};
      GOCD_GAUGE_OPT: rd_mux = {24'h0, gauge_q};
      GOCD_MISC_OPT: rd_mux = {16'h0, misc_q};
      GOCD_FILTER: rd_mux = {24'h0, filter_q};
      GOCD_DESIGN_CAP: rd_mux = {16'h0, design_cap_q};
      GOCD_FULL_CAP_INIT: rd_mux = {16'h0, full_cap_q};
      GOCD_CYCLE_THRESH: rd_mux = {16'h0, cyc_thresh_q};
      GOCD_CHG_EFF: rd_mux = {24'h0, eff_q};
      GOCD_CTRL: rd_mux = {30'h0, loaded_q, mwh_q};
      GOCD_CAP_ALARM: rd_mux = {16'h0, cap_alarm_q};
      GOCD_STATUS: rd_mux = {25'h0, once_done_q, sleep_out, cell_uv_flag_out,
        cell_ov_flag_out, safety_ov_out, edv_below_out, broadcast_en_out};
      GOCD_CYCLE_COUNT: rd_mux = {16'h0, cyc_count_q};
      GOCD_DESIGN_CAP_RPT: rd_mux = {16'h0, design_rpt};
      GOCD_REMAINING: rd_mux = {16'h0, rem_q};
      GOCD_FILTER_NV: rd_mux = {16'h0, filter_nv_out};
      default: begin
        rd_mux = 32'h0;
        known = 1'b0;
      end
    endcase
  end

  wire logic bad = !known || !hit;
  wire logic wlo = wr && pstrb_in[0] && !bad;
  wire logic whi = wr && pstrb_in[1] && !bad;

  // Zero-wait APB answer; unmapped addresses give pslverr
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      prdata_out <= 32'h0;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && bad;
      prdata_out <= (psel_in && !penable_in && !pwrite_in) ? rd_mux : 32'h0;
    end
  end
  // Data are taken when pready is seen high at the access edge
  wire logic take = pready_out;

  // Register writes, gated by byte strobe 0 alone; strobe 1 is ignored
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rem_time_q <= 16'h0; design_v_q <= 16'h0; cyc_init_q <= 16'h0;
      pack_q <= 8'h0; gauge_q <= 8'h0; misc_q <= GOCD_MISC_ONES;
      filter_q <= 8'h0; design_cap_q <= 16'h0; full_cap_q <= 16'h0;
      cyc_thresh_q <= 16'h0; eff_q <= 8'h0; cap_alarm_q <= 16'h0;
      mwh_q <= 1'b0; loaded_q <= 1'b0;
    end else if (take && wlo) begin
      case (reg_idx)
        GOCD_REM_TIME_ALARM: rem_time_q <= pwdata_in[15:0];
        GOCD_DESIGN_VOLTAGE: design_v_q <= pwdata_in[15:0];
        GOCD_CYCLE_INIT: cyc_init_q <= pwdata_in[15:0];
        GOCD_PACK_OPT: pack_q <= pwdata_in[7:0];
        GOCD_GAUGE_OPT: gauge_q <= pwdata_in[7:0] & GOCD_GAUGE_MASK;
        GOCD_MISC_OPT: misc_q <= (pwdata_in[15:0] & GOCD_MISC_MASK) | GOCD_MISC_ONES;
        GOCD_FILTER: filter_q <= pwdata_in[7:0];
        GOCD_DESIGN_CAP: design_cap_q <= pwdata_in[15:0];
        GOCD_FULL_CAP_INIT: full_cap_q <= pwdata_in[15:0];
        GOCD_CYCLE_THRESH: cyc_thresh_q <= pwdata_in[15:0];
        GOCD_CHG_EFF: eff_q <= pwdata_in[7:0];
        GOCD_CTRL: begin
          mwh_q <= pwdata_in[GOCD_C_MWH];
          loaded_q <= loaded_q | pwdata_in[GOCD_C_LOADED];
        end
        GOCD_CAP_ALARM: cap_alarm_q <= pwdata_in[15:0];
        default: ;
      endcase
    end
  end
  wire logic unused_hi = whi;

  ////////////////////////////////////////////////////////////////////////////
  // Option decode

  wire logic [15:0] misc_eff = loaded_q ? misc_q : GOCD_MISC_ONES;
  wire logic [7:0] pack_eff = loaded_q ? pack_q : 8'h0;
  wire logic [7:0] gauge_eff = loaded_q ? gauge_q : 8'h0;
  wire logic [1:0] cell_f = pack_eff[GOCD_P_CELL_HI:GOCD_P_CELL_LO];
  wire logic [2:0] cells = (cell_f == 2'h0) ? 3'h0 : 3'(cell_f) + 3'h1;
  wire logic [2:0] segs = seg_count(pack_eff[GOCD_P_LED_HI:GOCD_P_LED_LO]);
  wire logic [31:0] cap_x_v = design_cap_q * design_v_q;
  assign design_rpt = mwh_q ? 16'(cap_x_v / 32'(GOCD_MWH_DIV)) : design_cap_q;
  wire logic [15:0] cap_alarm_used = cap_alarm_q; // units follow mwh_q
  wire logic [15:0] time_alarm_used = rem_time_q;

  // End-of-discharge and safety comparisons
  wire logic [15:0] edv_v = gauge_eff[GOCD_G_EDSRC] ? meas_in.pack_mv : meas_in.min_cell_mv;
  wire logic [18:0] ov_v = gauge_eff[GOCD_G_OVSRC] ? 19'(meas_in.max_cell_mv * cells) :
    19'(meas_in.pack_mv);
  wire logic [15:0] edv_thresh = safety_mv_in;

  ////////////////////////////////////////////////////////////////////////////
  // Gauge arithmetic: cycle count, charge efficiency, capacity sync

  wire logic [16:0] dis_next = dis_acc_q + 17'(meas_in.dis_mah);
  wire logic cyc_hit = loaded_q && dis_pulse_in && (cyc_thresh_q != 16'h0) &&
    (dis_next >= 17'(cyc_thresh_q));
  wire logic [24:0] chg_scaled = meas_in.chg_mah * (9'(eff_q) + 9'h1);
  wire logic [24:0] chg_sum = 25'(chg_acc_q[7:0]) + chg_scaled;
  wire logic [23:0] sync_val = full_cap_q * sync_pct_in;

  // Remaining capacity next value
  always_comb begin
    rem_d = rem_q;
    if (!loaded_q) begin
      rem_d = full_cap_q;
    end else if (term_in && gauge_eff[GOCD_G_CAPACITY_SYNC_ON_TERM]) begin
      rem_d = 16'(sync_val / 24'd100);
    end else if (chg_pulse_in) begin
      rem_d = rem_q + 16'(chg_sum >> 8);
    end else if (dis_pulse_in) begin
      rem_d = (rem_q > meas_in.dis_mah) ? rem_q - meas_in.dis_mah : 16'h0;
    end
  end

  // Accumulators and counters of the gauge
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rem_q <= 16'h0; dis_acc_q <= 17'h0; chg_acc_q <= 17'h0;
      cyc_count_q <= 16'h0; cyc_loaded_q <= 1'b0; once_done_q <= 1'b0;
    end else begin
      rem_q <= rem_d;
      if (loaded_q && !cyc_loaded_q) begin
        cyc_count_q <= cyc_init_q;
        cyc_loaded_q <= 1'b1;
      end else if (cyc_hit) begin
        cyc_count_q <= cyc_count_q + 16'h1;
        dis_acc_q <= dis_next - 17'(cyc_thresh_q);
      end else if (loaded_q && dis_pulse_in) begin
        dis_acc_q <= dis_next;
      end
      if (loaded_q && chg_pulse_in) begin
        chg_acc_q <= {9'h0, chg_sum[7:0]};
      end
      if (midrange_go_out && !gauge_eff[GOCD_G_VCONT]) begin
        once_done_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timers: bus-idle sleep and cell flag delay

  wire logic bus_low = smb_clk_low_in && smb_dat_low_in;
  wire logic cell_any = cell_ov_in || cell_uv_in;
  // A long count keeps one comparator per timer rather than a prescaler
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      sleep_cnt_q <= 32'h0;
      delay_cnt_q <= 32'h0;
    end else begin
      sleep_cnt_q <= (bus_low && !misc_eff[GOCD_M_SLPINH]) ?
        ((sleep_cnt_q < 32'(SLEEP_CYC)) ? sleep_cnt_q + 32'h1 : sleep_cnt_q) : 32'h0;
      delay_cnt_q <= cell_any ?
        ((delay_cnt_q < 32'(CDELAY_CYC)) ? delay_cnt_q + 32'h1 : delay_cnt_q) : 32'h0;
    end
  end
  wire logic delay_ok = !misc_eff[GOCD_M_CDELAY] || (delay_cnt_q >= 32'(CDELAY_CYC));

  ////////////////////////////////////////////////////////////////////////////
  // Display and switch control

  wire logic [4:0] level = pack_eff[GOCD_P_DSRC] ? level_rel_in : level_abs_in;
  wire logic disp_on = !charging_in || misc_eff[GOCD_M_DISPCHG];
  wire logic [4:0] disp_lvl = level & seg_mask(segs);
  wire logic [4:0] disp_d = !disp_on ? 5'h0 :
    !cap_alarm_in ? disp_lvl :
    (misc_eff[GOCD_M_ABLANK] || !blink_in) ? 5'h0 : disp_lvl;
  // Non-removable pack keeps the opposite switch on and clears faults early
  wire logic fixed = misc_eff[GOCD_M_FIXED];
  wire logic f_chg = fault_chg_in && !(fixed && fault_clear_in);
  wire logic f_dis = fault_dis_in && !(fixed && fault_clear_in);
  wire logic chg_off = overtemp_in || (term_in && !misc_eff[GOCD_M_CHOLD]) ||
    f_chg || (f_dis && !fixed);
  wire logic dis_off = (overtemp_in && misc_eff[GOCD_M_OTDIS]) ||
    f_dis || (f_chg && !fixed);
  wire gocd_pre_t pre = gocd_pre_t'(misc_eff[GOCD_M_PRE_HI:GOCD_M_PRE_LO]);
  wire logic [2:0] pre_sel = (pre == GOCD_PRE_ZERO_VOLT) ? 3'h1 :
    (pre == GOCD_PRE_CHARGE) ? 3'h2 : (pre == GOCD_PRE_DISCHG) ? 3'h4 : 3'h0;

  gocd_opts_t opts_d;
  always_comb begin
    opts_d.display_source_select = pack_eff[GOCD_P_DSRC];
    opts_d.segments = segs;
    opts_d.host_alarm_checksum = pack_eff[GOCD_P_HPEC];
    opts_d.charger_broadcast_checksum = pack_eff[GOCD_P_CPEC];
    opts_d.broadcast_disable = pack_eff[GOCD_P_BDIS];
    opts_d.cells = cells;
    opts_d.capacity_sync_on_term = gauge_eff[GOCD_G_CAPACITY_SYNC_ON_TERM];
    opts_d.independent_charger_learning = gauge_eff[GOCD_G_INDEP];
    opts_d.end_discharge_compensation = gauge_eff[GOCD_G_COMP];
    opts_d.end_discharge_voltage_source = gauge_eff[GOCD_G_EDSRC];
    opts_d.safety_overvoltage_source = gauge_eff[GOCD_G_OVSRC];
    opts_d.internal_temp_sensor = misc_eff[GOCD_M_ITEMP];
    opts_d.front_end_comm_check = misc_eff[GOCD_M_AFECHK];
    opts_d.fixed_battery = fixed;
  end

  // Registered outputs
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      opts_out <= '0; display_out <= 5'h0; host_pec_out <= 1'b0;
      charger_pec_out <= 1'b0; broadcast_en_out <= 1'b0; sleep_out <= 1'b0;
      chg_switch_on_out <= 1'b0; dis_switch_on_out <= 1'b0;
      precharge_sel_out <= 3'h0; cell_ov_flag_out <= 1'b0; cell_uv_flag_out <= 1'b0;
      edv_below_out <= 1'b0; safety_ov_out <= 1'b0; midrange_go_out <= 1'b0;
      edv_compute_out <= 1'b0; filter_nv_out <= 16'h0; remaining_out <= 16'h0;
    end else begin
      opts_out <= opts_d;
      display_out <= loaded_q ? disp_d : 5'h0;
      host_pec_out <= pack_eff[GOCD_P_HPEC];
      charger_pec_out <= pack_eff[GOCD_P_CPEC];
      broadcast_en_out <= loaded_q && !pack_eff[GOCD_P_BDIS]; // mode bits not consulted
      sleep_out <= loaded_q && (sleep_cnt_q >= 32'(SLEEP_CYC));
      chg_switch_on_out <= loaded_q && !chg_off;
      dis_switch_on_out <= loaded_q && !dis_off;
      precharge_sel_out <= loaded_q ? pre_sel : 3'h0;
      cell_ov_flag_out <= cell_ov_in && delay_ok;
      cell_uv_flag_out <= cell_uv_in && delay_ok;
      edv_below_out <= loaded_q && (edv_v < edv_thresh);
      safety_ov_out <= loaded_q && (ov_v > 19'(safety_mv_in));
      midrange_go_out <= loaded_q && (gauge_eff[GOCD_G_VCONT] ||
        (gauge_eff[GOCD_G_VONCE] && !once_done_q && !midrange_go_out));
      edv_compute_out <= gauge_eff[GOCD_G_COMP];
      filter_nv_out <= 16'(filter_q * GOCD_FILTER_STEP_NV); // scale in nV
      remaining_out <= rem_q;
    end
  end
  wire logic [31:0] unused_ok = {time_alarm_used, cap_alarm_used} ^ {31'h0, unused_hi};

endmodule
`default_nettype wire

// ===== gocd_top_test.sv
// Self-checking bench for the option decode block
`timescale 1ns/1ns
`default_nettype none
module gocd_top_test import gocd_pkg::*;;
  logic clk_in = 0, rst_b_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, idle = 0;
  logic [9:0] paddr_in = '0;
  logic [7:0] sync_pct_in = '0;
  logic [31:0] pwdata_in = '0, prdata_out, rd, er, rs = 32'h56;
  logic [3:0] pstrb_in = 4'hf;
  gocd_meas_t meas_in = '0;
  logic dis_pulse_in = 0, chg_pulse_in = 0, term_in = 0, overtemp_in = 0, cell_ov_in = 0;
  logic cell_uv_in = 0, cap_alarm_in = 0, charging_in = 0, blink_in = 0, fault_chg_in = 0;
  logic fault_dis_in = 0, fault_clear_in = 0, smb_clk_low_in, smb_dat_low_in;
  logic [4:0] level_abs_in = '0, level_rel_in = '0, display_out;
  logic [15:0] safety_mv_in = '0, filter_nv_out, remaining_out;
  logic pready_out, pslverr_out, host_pec_out, charger_pec_out, broadcast_en_out, sleep_out;
  logic chg_switch_on_out, dis_switch_on_out, cell_ov_flag_out, cell_uv_flag_out;
  logic edv_below_out, safety_ov_out, midrange_go_out, edv_compute_out;
  logic [2:0] precharge_sel_out;
  gocd_opts_t opts_out;
  int failures = 0, checked = 0, model[int];
  int segs[4] = '{5, 3, 4, 5}, cels[4] = '{0, 2, 3, 4}, pres[4] = '{1, 2, 4, 0};
  logic [7:0] regs[11] = '{8'h02, 8'h04, 8'h0c, 8'h28, 8'h29, 8'h2a, 8'h2c, 8'h32, 8'h36,
    8'h37, 8'h54};
  // Short counts so sleep is reached quickly
  gocd_top #(.SLEEP_CYC(20), .CDELAY_CYC(10)) gocd_top_i (.clk_in, .rst_b_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out,
    .pslverr_out, .meas_in, .dis_pulse_in, .chg_pulse_in, .term_in, .sync_pct_in,
    .smb_clk_low_in, .smb_dat_low_in, .overtemp_in, .cell_ov_in, .cell_uv_in, .cap_alarm_in,
    .charging_in, .blink_in, .level_abs_in, .level_rel_in, .fault_chg_in, .fault_dis_in,
    .fault_clear_in, .safety_mv_in, .opts_out, .display_out, .host_pec_out, .charger_pec_out,
    .broadcast_en_out, .sleep_out, .chg_switch_on_out, .dis_switch_on_out, .precharge_sel_out,
    .cell_ov_flag_out, .cell_uv_flag_out, .edv_below_out, .safety_ov_out, .midrange_go_out,
    .edv_compute_out, .filter_nv_out, .remaining_out);
  gocd_smb_host gocd_smb_host_i (.clk_in, .rst_b_in, .idle_in(idle),
    .clk_low_out(smb_clk_low_in), .dat_low_out(smb_dat_low_in));
  always #2 clk_in = ~clk_in;
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // Writable bits per register; misc bit 9 always reads one
  function automatic logic [31:0] msk(input logic [7:0] a);
    case (a)
      8'h28, 8'h2c, 8'h54: return 32'hff;
      8'h29: return {24'h0, GOCD_GAUGE_MASK};
      8'h2a: return {16'h0, GOCD_MISC_MASK};
      default: return 32'hffff;
    endcase
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      failures++;
    end
  endtask
  task stop_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  // One APB transfer; request held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_in);
    psel_in <= 1;
    penable_in <= 0;
    pwrite_in <= w;
    paddr_in <= {a, 2'h0};
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    rd = prdata_out;
    er = {31'h0, pslverr_out};
    psel_in <= 0;
    penable_in <= 0;
    if (n >= 50) begin
      failures++;
      stop_test();
    end
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(0, a, 32'h0);
    chk(rd, exp);
  endtask
  initial begin
    logic [31:0] r;
    logic [7:0] p;
    cyc(4);
    rst_b_in <= 1;
    r = rnd();
    meas_in <= {r, rnd(), r[31:16]};
    {cap_alarm_in, charging_in, blink_in, cell_ov_in, cell_uv_in, fault_chg_in} <= r[5:0];
    {level_abs_in, level_rel_in, sync_pct_in} <= r[25:8];
    safety_mv_in <= r[15:0];
    foreach (regs[i]) begin
      r = rnd();
      apb(1, regs[i], r);
      model[regs[i]] = (r & msk(regs[i])) | (regs[i] == GOCD_MISC_OPT ? 32'h200 : 32'h0);
    end
    foreach (regs[i]) rdc(regs[i], model[regs[i]]);
    apb(0, 8'hfc, 32'h0);
    chk(er, 32'h1);
    chk(remaining_out, model[GOCD_FULL_CAP_INIT]);
    $display("register test done");
    apb(1, GOCD_CTRL, 32'h2);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      p = {r[7], i[1:0], r[4:2], i[1:0]};
      apb(1, GOCD_PACK_OPT, {24'h0, p});
      cyc(3);
      chk(opts_out.segments, segs[p[6:5]]);
      chk(opts_out.cells, cels[p[1:0]]);
      chk(opts_out.display_source_select, p[7]);
      chk({host_pec_out, charger_pec_out}, p[4:3]);
      chk(broadcast_en_out, !p[2]);
    end
    $display("pack option test done");
    p = rnd();
    apb(1, GOCD_FILTER, {24'h0, p});
    cyc(3);
    chk(filter_nv_out, 16'(p * GOCD_FILTER_STEP_NV));
    apb(1, GOCD_PACK_OPT, 32'h4);
    apb(1, GOCD_DESIGN_CAP, 32'd1000);
    apb(1, GOCD_DESIGN_VOLTAGE, 32'd14400);
    cyc(3);
    rdc(GOCD_DESIGN_CAP_RPT, 32'd1000);
    apb(1, GOCD_CTRL, 32'h3);
    cyc(3);
    rdc(GOCD_DESIGN_CAP_RPT, 32'(1000 * 14400 / 10000));
    chk(broadcast_en_out, 32'h0);
    apb(1, GOCD_GAUGE_OPT, 32'h58);
    term_in <= 1;
    cyc(1);
    term_in <= 0;
    cyc(2);
    chk(remaining_out, 16'(model[GOCD_FULL_CAP_INIT] * sync_pct_in / 100));
    chk(edv_compute_out, 32'h1);
    chk(edv_below_out, meas_in.pack_mv < safety_mv_in);
    chk(safety_ov_out, meas_in.pack_mv > safety_mv_in);
    chk({cell_ov_flag_out, cell_uv_flag_out}, {cell_ov_in, cell_uv_in});
    $display("capacity test done");
    apb(1, GOCD_MISC_OPT, 32'ha00);
    overtemp_in <= 1;
    cyc(4);
    chk({chg_switch_on_out, dis_switch_on_out}, 32'h0);
    overtemp_in <= 0;
    for (int i = 0; i < 4; i++) begin
      apb(1, GOCD_MISC_OPT, 32'h200 | (i << 5));
      cyc(3);
      chk(precharge_sel_out, pres[i]);
    end
    $display("switch test done");
    apb(1, GOCD_MISC_OPT, 32'h1200);
    idle <= 1;
    cyc(40);
    chk(sleep_out, 32'h0);
    apb(1, GOCD_MISC_OPT, 32'h200);
    cyc(40);
    chk(sleep_out, 32'h1);
    idle <= 0;
    chk(display_out, (charging_in || cap_alarm_in && !blink_in) ? 5'h0 : level_abs_in);
    $display("sleep test done");
    stop_test();
  end
endmodule
`default_nettype wire
